/* File: common/uff_link_if.sv */
// link between the control core and its serialiser and deserialiser
// assumes all three sit on one clock
`timescale 1ns/100ps
interface uff_link_if;
  import uff_pkg::*;
  logic ce;
  logic abort;
  logic [7:0] ctrl;
  logic [7:0] div;
  logic tx_go;
  logic [7:0] tx_byte;
  logic tx_busy;
  logic tx_done;
  logic txd;
  uff_phase_t tx_ph;
  logic rxd;
  logic rx_done;
  logic [8:0] rx_word;
  logic rx_ferr;
  logic rx_perr;
  logic rx_busy;
  modport ctl (output ce, abort, ctrl, div, tx_go, tx_byte, rxd,
               input tx_busy, tx_done, txd, tx_ph, rx_done, rx_word,
               rx_ferr, rx_perr, rx_busy);
  modport tx (input ce, abort, ctrl, div, tx_go, tx_byte,
              output tx_busy, tx_done, txd, tx_ph);
  modport rx (input ce, abort, ctrl, div, rxd,
              output rx_done, rx_word, rx_ferr, rx_perr, rx_busy);
endinterface : uff_link_if

/* File: common/uff_pkg.sv */
// frame-format control package: register map, field layout, phases
// assumes an 8-bit register port and one system clock
package uff_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] UFF_CTRL_ADDR = 8'hFB;
  localparam logic [7:0] UFF_STAT_ADDR = 8'hF0;
  localparam logic [7:0] UFF_MASK_ADDR = 8'hF1;
  localparam logic [7:0] UFF_TXD_ADDR = 8'hF2;
  localparam logic [7:0] UFF_RXD_ADDR = 8'hF3;
  localparam logic [7:0] UFF_RXS_ADDR = 8'hF4;
  localparam logic [7:0] UFF_BAUD_ADDR = 8'hF5;
  // ----------------------------------------------------------------
  // control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ABORT = 7;
  localparam int CTRL_FLOW = 6;
  localparam int CTRL_NINTH_VAL = 5;
  localparam int CTRL_NINE_BIT = 4;
  localparam int CTRL_PAR = 3;
  localparam int CTRL_STOP_CNT = 2;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_START = 0;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] CTRL_WMASK = 8'h7F;
  localparam logic [7:0] BAUD_RST = 8'h56;
  localparam int ST_TXDONE = 0;
  localparam int ST_RXDONE = 1;
  localparam int ST_FERR = 2;
  localparam int ST_PERR = 3;
  localparam int ST_W = 4;
  localparam int RXS_NINTH = 0;
  localparam int RXS_FULL = 1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int NINTH_POS = 8;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_START = 3'h1,
    PH_DATA = 3'h3,
    PH_NINTH = 3'h2,
    PH_STOP = 3'h6
  } uff_phase_t;

  function automatic logic uff_par(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : uff_par

  function automatic logic uff_ninth(input logic [7:0] d,
                                     input logic [7:0] c);
    return c[CTRL_PAR] ? uff_par(d, c[CTRL_NINTH_VAL]) : c[CTRL_NINTH_VAL];
  endfunction : uff_ninth

  function automatic logic uff_has9(input logic [7:0] c);
    return c[CTRL_NINE_BIT] | c[CTRL_PAR];
  endfunction : uff_has9
endpackage : uff_pkg

/* File: verification/uart_frame_format_control_tb.sv */
// bench: table of sent frames, then receive errors, flow, abort, irq
// assumes the peer model on the serial pins and 8 clocks per bit
`timescale 1ns/100ps
module uart_frame_format_control_tb;
  import uff_pkg::*;
  localparam int PER = 8;
  logic clk, arst_n, ce, wr_en, rd_en, sleep_wake, idle, stall;
  logic [7:0] addr, wr_data, rd_data, rv;
  logic txd, rxd, rts_n, cts_n, irq, hold;
  logic [11:0] sl, ex;
  int failures, n_tests, cyc;
  // control value beside the byte sent with it
  logic [15:0] rows [10] = '{16'h02A5, 16'h063C, 16'h0481, 16'h0081,
    16'h135A, 16'h335A, 16'h0A07, 16'h2A07, 16'h1EF0, 16'h3F01};

  uff_frame_ctrl uff_frame_ctrl_inst (.clk(clk), .arst_n(arst_n),
    .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .sleep_wake(sleep_wake),
    .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .irq(irq));
  uff_peer #(.PER(PER)) uff_peer_inst (.clk(clk), .line(txd),
    .idle(idle), .stall(stall), .rxd(rxd), .cts_n(cts_n));

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  // line samples after the start bit: data, ninth, stops, idle
  function automatic logic [11:0] exps(input logic [7:0] c,
                                       input logic [7:0] d);
    logic [11:0] s;
    int k;
    s = {4'h0, d} | ({12{~c[CTRL_START]}} & 12'hF00);
    k = 8;
    if (c[CTRL_NINE_BIT] | c[CTRL_PAR])
    begin
      s[8] = c[CTRL_PAR] ? (^d) ^ c[CTRL_NINTH_VAL] : c[CTRL_NINTH_VAL];
      k = 9;
    end
    s[k] = c[CTRL_STOP];
    if (c[CTRL_STOP_CNT])
      s[k + 1] = c[CTRL_STOP];
    return s;
  endfunction : exps

  task automatic rxt(input logic [7:0] c, input logic [8:0] w,
                     input logic s2, input logic [3:0] st);
    wr(UFF_CTRL_ADDR, c);
    idle <= ~c[CTRL_START];
    wr(UFF_STAT_ADDR, 8'h0F);
    uff_peer_inst.send(c[CTRL_START], w, 1'b1, c[CTRL_STOP], s2,
                       c[CTRL_STOP_CNT]);
    repeat (PER) @(posedge clk);
    rd(UFF_STAT_ADDR);
    chk("rx status", {8'h0, st}, {8'h0, rv[3:0] & 4'hE});
    chk("rts flow off", 12'h0, {11'h0, rts_n});
    rd(UFF_RXS_ADDR);
    hold = rv[RXS_NINTH];
    rd(UFF_RXD_ADDR);
    chk("rx word", {3'h0, w}, {3'h0, hold, rv});
  endtask : rxt

  task automatic quiet(input int n);
    hold = 1'b0;
    repeat (n) @(posedge clk) hold = hold | (txd !== 1'b1);
  endtask : quiet

  // --------------------------------
  // clock, timeout, sequence
  // --------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    {arst_n, wr_en, rd_en, sleep_wake, stall} = 5'h0;
    {ce, idle} = 2'h3;
    addr = 8'h00;
    wr_data = 8'h00;
    repeat (3) @(posedge clk);
    #1 chk("reset pins", 12'h001, {1'b0, rd_data, irq, rts_n, txd});
    @(posedge clk);
    arst_n <= 1'b1;
    rd(UFF_CTRL_ADDR);
    chk("ctrl reset", CTRL_RST, rv);
    rd(UFF_BAUD_ADDR);
    chk("baud reset", BAUD_RST, rv);
    wr(UFF_BAUD_ADDR, 8'(PER - 1));
    foreach (rows[i])
    begin
      wr(UFF_CTRL_ADDR, rows[i][15:8]);
      idle <= ~rows[i][8];
      repeat (3) @(posedge clk);
      wr(UFF_TXD_ADDR, rows[i][7:0]);
      uff_peer_inst.recv(rows[i][8], sl);
      ex = exps(rows[i][15:8], rows[i][7:0]);
      chk("frame data", ex & 12'h0FF, sl & 12'h0FF);
      chk("ninth", ex & 12'h100, sl & 12'h100);
      chk("stops", ex & 12'hE00, sl & 12'hE00);
    end
    rxt(8'h0A, 9'h035, 1'b1, 4'h2);
    rxt(8'h0A, 9'h135, 1'b1, 4'hA);
    rxt(8'h2E, 9'h135, 1'b0, 4'h6);
    // flow on: full buffer holds the far end off, stall holds us
    wr(UFF_CTRL_ADDR, 8'h42);
    uff_peer_inst.send(1'b0, 9'h0AA, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (PER) @(posedge clk);
    chk("rts full", 12'h1, {11'h0, rts_n});
    rd(UFF_RXD_ADDR);
    repeat (2) @(posedge clk);
    chk("rts drained", 12'h0, {11'h0, rts_n});
    stall <= 1'b1;
    wr(UFF_TXD_ADDR, 8'h55);
    quiet(5 * PER);
    chk("cts stall", 12'h0, {11'h0, hold});
    stall <= 1'b0;
    uff_peer_inst.recv(1'b0, sl);
    chk("frame after stall", exps(8'h42, 8'h55), sl);
    // abort mid-frame, then abort of a pending byte
    wr(UFF_CTRL_ADDR, 8'h02);
    wr(UFF_TXD_ADDR, 8'h00);
    repeat (3 * PER) @(posedge clk);
    wr(UFF_CTRL_ADDR, 8'h82);
    repeat (3) @(posedge clk);
    quiet(12 * PER);
    chk("abort idle", 12'h0, {11'h0, hold});
    rd(UFF_CTRL_ADDR);
    chk("abort reads 0", 12'h002, {4'h0, rv});
    wr(UFF_CTRL_ADDR, 8'h42);
    stall <= 1'b1;
    wr(UFF_TXD_ADDR, 8'h00);
    wr(UFF_CTRL_ADDR, 8'hC2);
    stall <= 1'b0;
    quiet(15 * PER);
    chk("pending dropped", 12'h0, {11'h0, hold});
    sleep_wake <= 1'b1;
    @(posedge clk);
    sleep_wake <= 1'b0;
    rd(UFF_CTRL_ADDR);
    chk("wake abort 0", 12'h0, {11'h0, rv[CTRL_ABORT]});
    // irq: masked, unmasked, cleared; unmapped place
    wr(UFF_MASK_ADDR, 8'h00);
    wr(UFF_STAT_ADDR, 8'h0F);
    wr(UFF_TXD_ADDR, 8'h11);
    uff_peer_inst.recv(1'b0, sl);
    chk("irq masked", 12'h0, {11'h0, irq});
    wr(UFF_MASK_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq raised", 12'h1, {11'h0, irq});
    wr(UFF_STAT_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 12'h0, {11'h0, irq});
    wr(8'h10, 8'hFF);
    rd(8'h10);
    chk("unmapped", 12'h0, {4'h0, rv});
    give_verdict();
  end
endmodule : uart_frame_format_control_tb

/* File: verification/uff_peer.sv */
// far-end serial device: sends frames on rxd, samples the device txd
// assumes a bit period of PER clocks and a bench-chosen idle level
`timescale 1ns/100ps
module uff_peer
#(
  parameter int PER = 8
)
(
  // clock
  input wire logic clk,
  // serial line and flow
  input wire logic line,
  input wire logic idle,
  input wire logic stall,
  output logic rxd,
  output logic cts_n
);
  logic drv;
  logic busy;

  initial
  begin
    drv = 1'b1;
    busy = 1'b0;
  end

  // between frames the line rests at the idle level, not the last bit
  assign rxd = busy ? drv : idle;
  assign cts_n = stall;

  // --------------------------------
  // frame out and frame in
  // --------------------------------
  task automatic send(input logic st, input logic [8:0] w, input logic h9,
                      input logic s1, input logic s2, input logic two);
    logic [11:0] b;
    int n;
    b = h9 ? {s2, s1, w, st} : {1'b0, s2, s1, w[7:0], st};
    @(posedge clk);
    busy <= 1'b1;
    for (n = 0; n < 10 + h9 + two; n++)
    begin
      drv <= b[n];
      repeat (PER) @(posedge clk);
    end
    busy <= 1'b0;
  endtask : send

  // twelve mid-bit samples after the start bit; x when none came
  task automatic recv(input logic st, output logic [11:0] s);
    int n;
    s = 'x;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk);
      if (line === st)
        break;
    end
    if (line === st)
    begin
      repeat (PER / 2) @(posedge clk);
      for (n = 0; n < 12; n++)
      begin
        repeat (PER) @(posedge clk);
        s[n] = line;
      end
    end
  endtask : recv
endmodule : uff_peer

/* File: verilog/uff_frame_ctrl.sv */
// async serial frame-format control: registers, flow control, irq
// assumes a plain register port and inputs synchronous to clk
`timescale 1ns/100ps

module uff_frame_ctrl
  import uff_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // power management
  input wire logic sleep_wake,
  // serial line
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic abort;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic [7:0] txbuf;
    logic tx_pend;
    logic go;
    logic [7:0] sent;
    logic [8:0] rxbuf;
    logic rx_full;
    logic [7:0] baud;
    logic [7:0] rd_data;
    logic irq;
    logic rts_n;
  } uff_st_t;

  localparam uff_st_t ST_RST = '{ctrl: CTRL_RST, baud: BAUD_RST,
    default: '0};

  uff_st_t q, d;
  uff_link_if lk ();

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] uff_rd(input logic [7:0] a,
                                        input uff_st_t s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      UFF_CTRL_ADDR:
        r = s.ctrl & CTRL_WMASK;
      UFF_STAT_ADDR:
        r = {{(8 - ST_W){1'b0}}, s.stat};
      UFF_MASK_ADDR:
        r = {{(8 - ST_W){1'b0}}, s.mask};
      UFF_TXD_ADDR:
        r = s.txbuf;
      UFF_RXD_ADDR:
        r = s.rxbuf[7:0];
      UFF_RXS_ADDR:
      begin
        r[RXS_NINTH] = s.rxbuf[NINTH_POS];
        r[RXS_FULL] = s.rx_full;
      end
      UFF_BAUD_ADDR:
        r = s.baud;
      default:
        r = 8'h00;
    endcase
    return r;
  endfunction : uff_rd

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [ST_W-1:0] set_v;
    logic [ST_W-1:0] clr_v;
    d = q;
    set_v = '0;
    clr_v = '0;
    d.abort = 1'b0;
    d.go = 1'b0;
    d.rd_data = 8'h00;

    // launch before the write so a byte written now is not lost
    if (q.tx_pend && !lk.tx_busy && !q.go &&
        (!q.ctrl[CTRL_FLOW] || !cts_n))
    begin
      d.go = 1'b1;
      d.tx_pend = 1'b0;
      d.sent = q.txbuf;
    end

    if (wr_en)
    begin
      case (addr)
        UFF_CTRL_ADDR:
        begin
          d.ctrl = wr_data & CTRL_WMASK;
          d.abort = wr_data[CTRL_ABORT];
        end
        UFF_STAT_ADDR:
          clr_v = wr_data[ST_W-1:0];
        UFF_MASK_ADDR:
          d.mask = wr_data[ST_W-1:0];
        UFF_TXD_ADDR:
        begin
          d.txbuf = wr_data;
          d.tx_pend = 1'b1;
        end
        UFF_BAUD_ADDR:
          d.baud = wr_data;
        default:
          d.tx_pend = d.tx_pend;
      endcase
    end

    if (rd_en)
    begin
      d.rd_data = uff_rd(addr, q);
      if (addr == UFF_RXD_ADDR)
        d.rx_full = 1'b0;
    end

    // receive after the read so a word landing now stays visible
    if (lk.rx_done)
    begin
      d.rxbuf = lk.rx_word;
      d.rx_full = 1'b1;
      set_v[ST_RXDONE] = 1'b1;
      set_v[ST_FERR] = lk.rx_ferr;
      set_v[ST_PERR] = lk.rx_perr;
    end
    if (lk.tx_done)
      set_v[ST_TXDONE] = 1'b1;

    if (d.abort)
    begin
      d.tx_pend = 1'b0;
      d.go = 1'b0;
    end
    if (sleep_wake)
      d.abort = 1'b0;

    // set beats clear: an event in the clearing cycle survives
    d.stat = (q.stat & ~clr_v) | set_v;
    d.irq = |(d.stat & d.mask);
    // rts deasserted only while handshaking and the buffer is full
    d.rts_n = d.ctrl[CTRL_FLOW] & d.rx_full;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= ST_RST;
    else if (ce)
      q <= d;
  end

  // ----------------------------------------------------------------
  // datapath units
  // ----------------------------------------------------------------
  assign lk.ce = ce;
  assign lk.abort = q.abort;
  assign lk.ctrl = q.ctrl;
  assign lk.div = q.baud;
  assign lk.tx_go = q.go;
  assign lk.tx_byte = q.sent;
  assign lk.rxd = rxd;

  uff_tx u_tx (
    .clk(clk),
    .arst_n(arst_n),
    .lk(lk.tx)
  );

  uff_rx u_rx (
    .clk(clk),
    .arst_n(arst_n),
    .lk(lk.rx)
  );

  assign rd_data = q.rd_data;
  assign irq = q.irq;
  assign rts_n = q.rts_n;
  assign txd = lk.txd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [9:0] stop_cnt_q;
  logic [9:0] stop_exp;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stop_cnt_q <= '0;
    else if (ce)
      stop_cnt_q <= (lk.tx_ph == PH_STOP) ? stop_cnt_q + 10'h001 : '0;
  end

  assign stop_exp = ({2'b00, q.baud} + 10'h001) << q.ctrl[CTRL_STOP_CNT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ctrl_abort_rd_a: assert property (
    rd_en && addr == UFF_CTRL_ADDR |=> !rd_data[CTRL_ABORT])
    else $error("abort bit read back as one");

  abort_idle_a: assert property (
    q.abort && ce |=> !lk.tx_busy && !lk.rx_busy)
    else $error("unit not idle after abort");

  wake_abort_a: assert property (
    sleep_wake |=> !q.abort)
    else $error("abort set after wake");

  flow_gate_a: assert property (
    $rose(q.go) |-> !$past(q.ctrl[CTRL_FLOW]) || !$past(cts_n))
    else $error("frame launched while cts deasserted");

  rts_track_a: assert property (
    rts_n == (q.ctrl[CTRL_FLOW] && q.rx_full))
    else $error("rts does not follow buffer state");

  ninth_bit_a: assert property (
    lk.tx_ph == PH_NINTH && $past(lk.tx_ph) == PH_DATA &&
    $stable(q.ctrl) && $past(q.ctrl) == $past(q.ctrl, 2)
    |-> txd == uff_ninth(q.sent, q.ctrl))
    else $error("wrong ninth bit on line");

  frame_len_a: assert property (
    $past(lk.tx_ph) == PH_DATA && lk.tx_ph != PH_DATA &&
    !$past(q.abort) && $stable(q.ctrl)
    |-> (lk.tx_ph == PH_NINTH) == uff_has9(q.ctrl))
    else $error("frame length does not match setting");

  stop_len_a: assert property (
    $past(lk.tx_ph) == PH_STOP && lk.tx_ph == PH_IDLE &&
    !$past(q.abort) && $stable(q.ctrl) && $stable(q.baud)
    |-> stop_cnt_q == stop_exp)
    else $error("stop time does not match stop count");

  stop_level_a: assert property (
    lk.tx_ph == PH_STOP && $past(lk.tx_ph) != PH_STOP &&
    $stable(q.ctrl) |-> txd == q.ctrl[CTRL_STOP])
    else $error("stop bit at wrong level");

  idle_level_a: assert property (
    lk.tx_ph == PH_IDLE && $past(lk.tx_ph) == PH_IDLE &&
    $stable(q.ctrl) |-> txd == !q.ctrl[CTRL_START])
    else $error("idle line not opposite of start level");

  ferr_flag_a: assert property (
    $rose(q.stat[ST_FERR]) |-> $past(lk.rx_ferr))
    else $error("framing flag set without cause");

  perr_flag_a: assert property (
    $rose(q.stat[ST_PERR]) |-> $past(lk.rx_perr))
    else $error("parity flag set without cause");

  rx_frame_c: cover property (lk.rx_done);
  flow_launch_c: cover property ($rose(q.go) && q.ctrl[CTRL_FLOW]);
  ninth_sent_c: cover property (lk.tx_ph == PH_NINTH);
  abort_busy_c: cover property (q.abort && lk.tx_busy);
endmodule : uff_frame_ctrl

/* File: verilog/uff_rx.sv */
// frame deserialiser with mid-bit sampling and error checks
// assumes rxd is already synchronous to clk
`timescale 1ns/100ps
module uff_rx
  import uff_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // core link
  uff_link_if.rx lk
);
  typedef struct packed {
    uff_phase_t ph;
    logic [7:0] cnt;
    logic [3:0] bit_n;
    logic [8:0] sh;
    logic ferr;
    logic done;
    logic frm_bad;
    logic pe;
    logic [8:0] word;
  } uff_rx_st_t;
  localparam uff_rx_st_t RX_RST = '{ph: PH_IDLE, default: '0};
  uff_rx_st_t q, d;
  logic tick;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    tick = (q.cnt == lk.div);
    d.cnt = tick ? '0 : q.cnt + 8'h01;
    case (q.ph)
      PH_IDLE:
      begin
        d.cnt = '0;
        d.ferr = 1'b0;
        d.bit_n = '0;
        if (lk.rxd == lk.ctrl[CTRL_START])
          d.ph = PH_START;
      end
      PH_START:
        if (q.cnt == (lk.div >> 1))
        begin
          // a glitch shorter than half a bit is dropped here
          d.ph = (lk.rxd == lk.ctrl[CTRL_START]) ? PH_DATA : PH_IDLE;
          d.cnt = '0;
        end
      PH_DATA:
        if (tick)
        begin
          d.sh[q.bit_n] = lk.rxd;
          d.bit_n = q.bit_n + 4'h1;
          if (q.bit_n == LAST_BIT)
          begin
            d.ph = uff_has9(lk.ctrl) ? PH_NINTH : PH_STOP;
            d.bit_n = '0;
          end
        end
      PH_NINTH:
        if (tick)
        begin
          d.sh[NINTH_POS] = lk.rxd;
          d.ph = PH_STOP;
        end
      PH_STOP:
        if (tick)
        begin
          d.ferr = q.ferr | (lk.rxd != lk.ctrl[CTRL_STOP]);
          if (lk.ctrl[CTRL_STOP_CNT] && q.bit_n == '0)
            d.bit_n = 4'h1;
          else
          begin
            d.ph = PH_IDLE;
            d.done = 1'b1;
            d.frm_bad = d.ferr;
            d.pe = lk.ctrl[CTRL_PAR] &&
              (q.sh[NINTH_POS] != uff_par(q.sh[7:0],
                                          lk.ctrl[CTRL_NINTH_VAL]));
            d.word = uff_has9(lk.ctrl) ? q.sh : {1'b0, q.sh[7:0]};
          end
        end
      default:
        d = RX_RST;
    endcase
    if (lk.abort)
      d = RX_RST;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= RX_RST;
    else if (lk.ce)
      q <= d;
  end

  assign lk.rx_done = q.done;
  assign lk.rx_word = q.word;
  assign lk.rx_ferr = q.done & q.frm_bad;
  assign lk.rx_perr = q.done & q.pe;
  assign lk.rx_busy = (q.ph != PH_IDLE);
endmodule : uff_rx

/* File: verilog/uff_tx.sv */
// frame serialiser: start, 8 data lsb first, optional ninth, stops
// assumes a bit period of div+1 clocks
`timescale 1ns/100ps
module uff_tx
  import uff_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // core link
  uff_link_if.tx lk
);
  typedef struct packed {
    uff_phase_t ph;
    logic [7:0] cnt;
    logic [3:0] bit_n;
    logic [8:0] sh;
    logic line;
    logic done;
  } uff_tx_st_t;
  localparam uff_tx_st_t TX_RST = '{ph: PH_IDLE,
    line: ~CTRL_RST[CTRL_START], default: '0};
  uff_tx_st_t q, d;
  logic tick;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    tick = (q.cnt == lk.div);
    d.cnt = tick ? '0 : q.cnt + 8'h01;
    case (q.ph)
      PH_IDLE:
      begin
        d.cnt = '0;
        d.line = ~lk.ctrl[CTRL_START];
        if (lk.tx_go)
        begin
          d.ph = PH_START;
          d.line = lk.ctrl[CTRL_START];
          d.sh = {uff_ninth(lk.tx_byte, lk.ctrl), lk.tx_byte};
          d.bit_n = '0;
        end
      end
      PH_START, PH_DATA:
        if (tick)
        begin
          d.bit_n = (q.ph == PH_DATA) ? q.bit_n + 4'h1 : '0;
          d.line = q.sh[0];
          d.sh = q.sh >> 1;
          d.ph = PH_DATA;
          if (q.ph == PH_DATA && q.bit_n == LAST_BIT)
          begin
            d.ph = uff_has9(lk.ctrl) ? PH_NINTH : PH_STOP;
            d.line = uff_has9(lk.ctrl) ? q.sh[0] : lk.ctrl[CTRL_STOP];
            d.bit_n = '0;
          end
        end
      PH_NINTH:
        if (tick)
        begin
          d.ph = PH_STOP;
          d.line = lk.ctrl[CTRL_STOP];
        end
      PH_STOP:
        if (tick)
        begin
          if (lk.ctrl[CTRL_STOP_CNT] && q.bit_n == '0)
            d.bit_n = 4'h1;
          else
          begin
            d.ph = PH_IDLE;
            d.done = 1'b1;
            d.line = ~lk.ctrl[CTRL_START];
          end
        end
      default:
        d = TX_RST;
    endcase
    if (lk.abort)
      d = '{ph: PH_IDLE, line: ~lk.ctrl[CTRL_START], default: '0};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= TX_RST;
    else if (lk.ce)
      q <= d;
  end

  assign lk.tx_busy = (q.ph != PH_IDLE);
  assign lk.tx_done = q.done;
  assign lk.txd = q.line;
  assign lk.tx_ph = q.ph;
endmodule : uff_tx
